//--- hdl/imd_pkg.sv
// Shared definitions for the integer subtract, product and quotient datapath.
// Assumes one core clock and a register file outside the block.
package imd_pkg;

	// ========================================================================
	// Instruction layout
	// ========================================================================
	localparam int XLEN    = 64;
	localparam int IMM_LSB = 12;
	localparam int IMM_W   = 8;

	// Element size, two bits
	typedef enum logic [1:0] {
		SZ_8  = 2'h0,
		SZ_16 = 2'h1,
		SZ_32 = 2'h2,
		SZ_64 = 2'h3
	} imd_size_t;

	// Three-register view; immediate forms reuse bits 19..12 as the constant
	typedef struct packed {
		logic [7:0] opc;
		imd_size_t  size;
		logic       simd;
		logic       f20;
		logic       f19;
		logic       f18;
		logic [5:0] src2;
		logic [5:0] src1;
		logic [5:0] dst;
	} imd_insn_t;

	// Operation class, one-hot
	typedef enum logic [4:0] {
		K_NONE  = 5'h00,
		K_MINUS = 5'h01,
		K_PROD  = 5'h02,
		K_PRODC = 5'h04,
		K_QUOT  = 5'h08,
		K_QUOTC = 5'h10
	} imd_kind_t;

	// One register-file write port
	typedef struct packed {
		logic            we;
		logic [5:0]      idx;
		logic [XLEN-1:0] data;
	} imd_wr_t;

	// Pipeline slot for two-cycle operations
	typedef struct packed {
		logic            v;
		logic            two;
		logic [5:0]      idx;
		logic [XLEN-1:0] lo;
		logic [XLEN-1:0] hi;
	} imd_slot_t;

	// ========================================================================
	// Registers and events
	// ========================================================================
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK   = 8'h04;
	localparam logic [7:0] REG_FAULT  = 8'h08;
	localparam int         ST_FAULT   = 0;
	localparam int         ST_ACCEPT  = 1;
	localparam int         ST_BADOP   = 2;
	localparam int         ST_W       = 3;
	localparam logic [2:0] ST_RESET   = 3'h0;

endpackage

//--- hdl/imd_datapath.sv
// Integer subtract-constant, product and quotient execution datapath.
// Assumes issue stage and register file on the same clock, feeding operand
// values beside the instruction and taking up to two writes per operation.
// What this block does
// - minus-constant subtracts zero-extended 8-bit constant from source.
// - constant forms: opcode, 4 flags, constant 19..12, source, target.
// - bits 23..22 pick element size; operation runs at that width.
// - bit 21 splits operands into parallel lanes of that size.
// - minus-constant takes 1 cycle for bytes, 2 otherwise; one per cycle, but a byte one right behind a two-cycle op waits a cycle.
// - register forms: opcode, 6 flags, second, first source, target.
// - product writes low half of each product to target.
// - product bit 19 selects signed operands, else unsigned.
// - product bit 18 also writes high half to target index xor 1.
// - product-constant sign-extends the constant to operand size.
// - quotient divides second-source operand by first-source operand.
// - zero divisor register raises a math fault.
// - quotient bit 19 selects signed division, else unsigned.
// - quotient bit 20 also writes remainder to target index xor 1.
// - quotient-constant sign-extends divisor; zero constant faults.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module imd_datapath #(
	parameter logic [7:0] OPC_MINUS_C = 8'h01, // Arbitrary opcode value
	parameter logic [7:0] OPC_PROD    = 8'h02, // Arbitrary opcode value
	parameter logic [7:0] OPC_PROD_C  = 8'h03, // Arbitrary opcode value
	parameter logic [7:0] OPC_QUOT    = 8'h04, // Arbitrary opcode value
	parameter logic [7:0] OPC_QUOT_C  = 8'h05  // Arbitrary opcode value
) (
	input  wire logic              clk_sys_i,     // Core clock
	input  wire logic              reset_i,       // Sync reset, high
	input  wire logic              ce_i,          // Clock enable
	input  wire logic              issue_valid_i, // Instruction offered
	output logic                   issue_ready_o, // Instruction taken
	input  wire logic [31:0]       insn_i,        // Instruction word
	input  wire logic [63:0]       src1_val_i,    // Value of reg bits 11..6
	input  wire logic [63:0]       src2_val_i,    // Value of reg bits 17..12
	output imd_pkg::imd_wr_t       wr0_o,         // Target write
	output imd_pkg::imd_wr_t       wr1_o,         // Neighbour write
	output logic                   fault_o,       // Math fault request
	input  wire logic [7:0]        reg_addr_i,    // Register address
	input  wire logic [31:0]       reg_wdata_i,   // Register write data
	input  wire logic              reg_wr_i,      // Register write strobe
	input  wire logic              reg_rd_i,      // Register read strobe
	output logic [31:0]            reg_rdata_o,   // Read data, next cycle
	output logic                   irq_o          // Interrupt level
);

	// ========================================================================
	// Decode
	// ========================================================================
	imd_pkg::imd_insn_t         ins;
	imd_pkg::imd_kind_t         kind;
	logic [imd_pkg::IMM_W-1:0]  imm;
	logic                       imm_use;
	logic                       imm_sx;
	logic                       sgn;
	logic                       is_prod;
	logic                       is_quot;
	logic                       two;
	logic                       lat1;
	logic                       fire;
	logic                       go;
	logic                       badop;
	logic                       divzero;
	logic [63:0]                opa;
	logic [63:0]                opb;
	logic [63:0]                res_lo;
	logic [63:0]                res_hi;
	imd_pkg::imd_slot_t         s1_q;

	// Fixed field positions of both formats
	assign ins = imd_pkg::imd_insn_t'(insn_i);
	assign imm = insn_i[imd_pkg::IMM_LSB +: imd_pkg::IMM_W];

	// Opcode match; an unknown opcode is taken and dropped
	always_comb begin
		if (ins.opc == OPC_MINUS_C) begin
			kind = imd_pkg::K_MINUS;
		end else if (ins.opc == OPC_PROD) begin
			kind = imd_pkg::K_PROD;
		end else if (ins.opc == OPC_PROD_C) begin
			kind = imd_pkg::K_PRODC;
		end else if (ins.opc == OPC_QUOT) begin
			kind = imd_pkg::K_QUOT;
		end else if (ins.opc == OPC_QUOT_C) begin
			kind = imd_pkg::K_QUOTC;
		end else begin
			kind = imd_pkg::K_NONE;
		end
	end

	// Operation controls
	assign is_prod = (kind == imd_pkg::K_PROD) || (kind == imd_pkg::K_PRODC);
	assign is_quot = (kind == imd_pkg::K_QUOT) || (kind == imd_pkg::K_QUOTC);
	assign imm_use = (kind == imd_pkg::K_MINUS) || (kind == imd_pkg::K_PRODC)
		|| (kind == imd_pkg::K_QUOTC);
	assign imm_sx  = (kind == imd_pkg::K_PRODC) || (kind == imd_pkg::K_QUOTC);
	// Register forms take the sign flag; the constant divide runs signed
	assign sgn = ((kind == imd_pkg::K_PROD) && ins.f19)
		|| ((kind == imd_pkg::K_QUOT) && ins.f19)
		|| (kind == imd_pkg::K_QUOTC);
	// Bit 20 of the constant forms is looked at only by the constant divide
	assign two = ((kind == imd_pkg::K_PROD) && ins.f18)
		|| (is_quot && ins.f20);
	// Dividend is the second source, divisor the first
	assign opa = (kind == imd_pkg::K_QUOT) ? src2_val_i : src1_val_i;
	assign opb = (kind == imd_pkg::K_QUOT) ? src1_val_i : src2_val_i;

	// Byte minus-constant finishes a cycle early, so it cannot follow a
	// two-cycle op that would reach the write port in the same cycle
	assign lat1 = (kind == imd_pkg::K_MINUS) && (ins.size == imd_pkg::SZ_8);
	assign issue_ready_o = !(lat1 && s1_q.v);
	assign fire    = issue_valid_i && issue_ready_o && ce_i;
	assign fault_o = fire && is_quot && divzero;
	assign badop   = fire && (kind == imd_pkg::K_NONE);
	assign go      = fire && !fault_o && (kind != imd_pkg::K_NONE);

	// ========================================================================
	// Lanes, one set per element size
	// ========================================================================
	// Nets, since every lane drives its own slice of the same vector
	wire logic [3:0][63:0] lo_v;
	wire logic [3:0][63:0] hi_v;
	wire logic [3:0][63:0] msk_v;
	wire logic [3:0][7:0]  z_v;

	// Every size is computed at once; the size field picks one afterwards
	for (genvar s = 0; s < 4; s++) begin : g_sz
		localparam int W = 8 << s;
		localparam int N = 8 >> s;
		localparam logic [63:0] M = (s == 3) ? 64'hffff_ffff_ffff_ffff
			: ((64'h1 << W) - 64'h1);
		assign msk_v[s] = M;
		for (genvar l = 0; l < 8; l++) begin : g_ln
			if (l < N) begin : g_on
				logic [W-1:0]   a;
				logic [W-1:0]   b;
				logic [W-1:0]   q;
				logic [W-1:0]   r;
				logic [2*W-1:0] ea;
				logic [2*W-1:0] eb;
				logic [2*W-1:0] p;
				assign a = opa[l*W +: W];
				// Constant: zero-extended for minus, sign-extended else
				assign b = !imm_use ? opb[l*W +: W]
					: imm_sx ? W'($signed(imm))
					: W'(imm);
				// Sign flag extends the top bit of each operand
				assign ea = {{W{sgn & a[W-1]}}, a};
				assign eb = {{W{sgn & b[W-1]}}, b};
				assign p  = ea * eb;
				// Zero divisor gives zero; the fault kills the result
				assign q = (b == '0) ? '0
					: sgn ? W'($signed(a) / $signed(b))
					: a / b;
				assign r = (b == '0) ? '0
					: sgn ? W'($signed(a) % $signed(b))
					: a % b;
				assign lo_v[s][l*W +: W] = (kind == imd_pkg::K_MINUS)
					? a - b
					: is_prod ? p[W-1:0] : q;
				assign hi_v[s][l*W +: W] = is_prod ? p[2*W-1:W] : r;
				assign z_v[s][l] = (b == '0);
			end else begin : g_off
				assign z_v[s][l] = 1'b0;
			end
		end
	end

	// Scalar mode keeps lane 0 only; SIMD keeps every lane
	assign res_lo = lo_v[ins.size] & (ins.simd ? '1 : msk_v[ins.size]);
	assign res_hi = hi_v[ins.size] & (ins.simd ? '1 : msk_v[ins.size]);
	// Any zero lane faults in SIMD mode
	assign divzero = ins.simd ? |z_v[ins.size] : z_v[ins.size][0];

	// ========================================================================
	// Pipeline and write ports
	// ========================================================================

	// Stage slot for all two-cycle operations
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s1_q <= '0;
		end else if (ce_i) begin
			s1_q.v   <= go && !lat1;
			s1_q.two <= two;
			s1_q.idx <= ins.dst;
			s1_q.lo  <= res_lo;
			s1_q.hi  <= res_hi;
		end
	end

	// Write ports load straight from the lanes for byte minus-constant, else from the slot
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr0_o <= '0;
			wr1_o <= '0;
		end else if (ce_i) begin
			if (go && lat1) begin
				wr0_o <= '{we: 1'b1, idx: ins.dst, data: res_lo};
				wr1_o.we <= 1'b0;
			end else if (s1_q.v) begin
				wr0_o    <= '{we: 1'b1, idx: s1_q.idx, data: s1_q.lo};
				wr1_o.we   <= s1_q.two;
				wr1_o.idx  <= s1_q.idx ^ 6'h01;
				wr1_o.data <= s1_q.hi;
			end else begin
				wr0_o.we <= 1'b0;
				wr1_o.we <= 1'b0;
			end
		end
	end

	// ========================================================================
	// Registers and interrupt
	// ========================================================================
	logic [imd_pkg::ST_W-1:0] status;
	logic [imd_pkg::ST_W-1:0] mask;
	logic [imd_pkg::ST_W-1:0] ev;
	logic [imd_pkg::ST_W-1:0] clr;
	logic [31:0]              fault_insn;

	assign ev = {badop, go, fault_o};
	assign clr = (reg_wr_i && (reg_addr_i == imd_pkg::REG_STATUS))
		? reg_wdata_i[imd_pkg::ST_W-1:0] : '0;

	// Sticky events; a new event beats a write-one clear in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			status <= imd_pkg::ST_RESET;
		end else if (ce_i) begin
			status <= (status & ~clr) | ev;
		end
	end

	// Mask register
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			mask <= imd_pkg::ST_RESET;
		end else if (ce_i && reg_wr_i && (reg_addr_i == imd_pkg::REG_MASK)) begin
			mask <= reg_wdata_i[imd_pkg::ST_W-1:0];
		end
	end

	// Last faulting instruction, for the trap handler
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			fault_insn <= 32'h0;
		end else if (ce_i && fault_o) begin
			fault_insn <= insn_i;
		end
	end

	// Read data stand one cycle only, zero otherwise and for holes
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			reg_rdata_o <= 32'h0;
		end else if (ce_i) begin
			if (!reg_rd_i) begin
				reg_rdata_o <= 32'h0;
			end else if (reg_addr_i == imd_pkg::REG_STATUS) begin
				reg_rdata_o <= 32'(status);
			end else if (reg_addr_i == imd_pkg::REG_MASK) begin
				reg_rdata_o <= 32'(mask);
			end else if (reg_addr_i == imd_pkg::REG_FAULT) begin
				reg_rdata_o <= fault_insn;
			end else begin
				reg_rdata_o <= 32'h0;
			end
		end
	end

	assign irq_o = |(status & mask);

	// ========================================================================
	// Checks
	// ========================================================================
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i || !ce_i);

	sequence s_wide_go;
		go && !lat1;
	endsequence

	sequence s_sub16_go;
		go && (kind == imd_pkg::K_MINUS) && !ins.simd
			&& (ins.size == imd_pkg::SZ_16);
	endsequence

	a_byte_sub_lat: assert property (
		go && lat1 |=> wr0_o.we && (wr0_o.idx == $past(ins.dst)))
		else $error("byte minus result not written after one cycle");

	a_wide_op_lat: assert property (
		s_wide_go |-> ##2 wr0_o.we && (wr0_o.idx == $past(ins.dst, 2)))
		else $error("wide result not written after two cycles");

	a_sub_zero_ext: assert property (
		s_sub16_go |-> ##2 (wr0_o.data[15:0]
			== $past(src1_val_i[15:0], 2) - {8'h00, $past(imm, 2)}))
		else $error("minus constant not zero-extended");

	a_dual_write: assert property (
		go && two |-> ##2 wr1_o.we && (wr1_o.idx == ($past(ins.dst, 2) ^ 6'h01)))
		else $error("neighbour write missing or misplaced");

	a_div_zero: assert property (
		fire && (kind == imd_pkg::K_QUOT) && !ins.simd
			&& (ins.size == imd_pkg::SZ_64) && (src1_val_i == 64'h0)
		|-> fault_o)
		else $error("zero divisor did not fault");

	a_divc_zero: assert property (
		fire && (kind == imd_pkg::K_QUOTC) && (imm == 8'h00) |-> fault_o)
		else $error("zero constant divisor did not fault");

	a_fault_quiet: assert property (
		fault_o |=> !s1_q.v)
		else $error("faulting op entered the pipeline");

	a_fault_sticky: assert property (
		fault_o |=> status[imd_pkg::ST_FAULT])
		else $error("fault event not recorded");

	a_rd_hole: assert property (
		reg_rd_i && (reg_addr_i != imd_pkg::REG_STATUS)
			&& (reg_addr_i != imd_pkg::REG_MASK)
			&& (reg_addr_i != imd_pkg::REG_FAULT)
		|=> reg_rdata_o == 32'h0)
		else $error("unmapped read returned data");

	a_stall_cause: assert property (
		!issue_ready_o |-> s1_q.v && $past(go))
		else $error("issue stalled without a pending slot");

	// Byte scalar forms, held against plain arithmetic on the operands
	sequence s_prod8_go;
		go && (kind == imd_pkg::K_PROD) && !ins.simd
			&& (ins.size == imd_pkg::SZ_8) && !ins.f19;
	endsequence

	sequence s_quot8_go;
		go && (kind == imd_pkg::K_QUOT) && !ins.simd
			&& (ins.size == imd_pkg::SZ_8) && !ins.f19;
	endsequence

	a_prod_low_half: assert property (
		s_prod8_go |-> ##2 (wr0_o.data[7:0]
			== $past(src1_val_i[7:0], 2) * $past(src2_val_i[7:0], 2)))
		else $error("product low half wrong");

	a_prod_high_half: assert property (
		s_prod8_go ##0 ins.f18 |-> ##2 (wr1_o.data[7:0]
			== 8'((16'($past(src1_val_i[7:0], 2))
			* 16'($past(src2_val_i[7:0], 2))) >> 8)))
		else $error("product high half wrong");

	a_quot_unsigned: assert property (
		s_quot8_go |-> ##2 (wr0_o.data[7:0]
			== $past(src2_val_i[7:0], 2) / $past(src1_val_i[7:0], 2)))
		else $error("unsigned quotient wrong");

	// Clear only when no new fault arrives, as the event wins the race
	a_status_clear: assert property (
		reg_wr_i && (reg_addr_i == imd_pkg::REG_STATUS)
			&& reg_wdata_i[imd_pkg::ST_FAULT] && !fault_o
		|=> !status[imd_pkg::ST_FAULT])
		else $error("write-one clear of fault bit lost");

endmodule // imd_datapath

`default_nettype wire

//--- dv/imd_issue_model.sv
// Issue stage and register file model facing the datapath.
// Assumes the bench calls offer() and idle() right after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module imd_issue_model (
	input  wire logic             clk_sys_i,     // Core clock
	input  wire logic             issue_ready_i, // Offer taken at edge
	input  wire logic             fault_i,       // Math fault request
	input  wire imd_pkg::imd_wr_t wr0_i,         // Target write
	input  wire imd_pkg::imd_wr_t wr1_i,         // Neighbour write
	output logic                  issue_valid_o, // Offer present
	output logic [31:0]           insn_o,        // Instruction word
	output logic [63:0]           src1_val_o,    // Value of bits 11..6
	output logic [63:0]           src2_val_o     // Value of bits 17..12
);
	// ========================================================================
	// Register file
	// ========================================================================
	logic [63:0] rf [64];

	// Idle operands are inverted so a stale value never passes for a live one
	assign src1_val_o = issue_valid_o ? rf[insn_o[11:6]]
		: ~rf[insn_o[11:6]];
	assign src2_val_o = issue_valid_o ? rf[insn_o[17:12]]
		: ~rf[insn_o[17:12]];

	// Write-back of both result ports
	always @(posedge clk_sys_i) begin
		if (wr0_i.we)
			rf[wr0_i.idx] <= wr0_i.data;
		if (wr1_i.we)
			rf[wr1_i.idx] <= wr1_i.data;
	end

	// ========================================================================
	// Issue handshake
	// ========================================================================
	initial begin
		issue_valid_o = 1'b0;
		insn_o = '0;
	end

	// Holds the offer until ready is seen; returns what the datapath saw
	// and how many cycles the offer had to wait
	task automatic offer(input logic [31:0] w, output logic [63:0] a1,
			output logic [63:0] a2, output logic flt, output logic tk,
			output int nw);
		tk = 1'b0;
		nw = 0;
		issue_valid_o <= 1'b1;
		insn_o <= w;
		for (int t = 0; t < 10 && !tk; t++) begin
			@(negedge clk_sys_i);
			tk = issue_ready_i;
			nw = t;
			a1 = src1_val_o;
			a2 = src2_val_o;
			flt = fault_i;
			@(posedge clk_sys_i);
		end
	endtask

	// Release the issue port
	task automatic idle();
		issue_valid_o <= 1'b0;
		insn_o <= ~insn_o;
	endtask
endmodule // imd_issue_model

`default_nettype wire

//--- dv/tb_integer_sub_mul_div_datapath.sv
// Self-checking bench for the subtract, product and quotient datapath.
// Assumes the issue model stands in for issue stage and register file.
`timescale 1ns/1ps
`default_nettype none

module tb_integer_sub_mul_div_datapath;
	typedef struct {
		int          due;
		logic        two;
		logic [5:0]  idx;
		logic [63:0] lo;
		logic [63:0] hi;
	} imd_exp_t;
	localparam logic [7:0] OPC [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05};

	logic             clk_sys_i;
	logic             reset_i;
	logic             ce_i;
	logic             issue_valid_i;
	logic             issue_ready_o;
	logic             fault_o;
	logic             irq_o;
	logic             reg_wr_i;
	logic             reg_rd_i;
	logic [7:0]       reg_addr_i;
	logic [31:0]      insn_i;
	logic [31:0]      reg_wdata_i;
	logic [31:0]      reg_rdata_o;
	logic [63:0]      src1_val_i;
	logic [63:0]      src2_val_i;
	imd_pkg::imd_wr_t wr0_o;
	imd_pkg::imd_wr_t wr1_o;
	imd_exp_t         q[$];
	int               n_mismatch;
	int               num_checks;
	int               cyc;
	logic [15:0]      seed;
	logic [2:0]       exp_st;
	logic [2:0]       exp_mask;
	logic [31:0]      exp_fi;
	logic [31:0]      w;
	logic [63:0]      v;
	logic             hit;
	logic             prev2;

	// ========================================================================
	// Design and partner
	// ========================================================================
	imd_datapath #(.OPC_MINUS_C(OPC[0]), .OPC_PROD(OPC[1]),
		.OPC_PROD_C(OPC[2]), .OPC_QUOT(OPC[3]), .OPC_QUOT_C(OPC[4])) uut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
		.issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o),
		.insn_i(insn_i), .src1_val_i(src1_val_i), .src2_val_i(src2_val_i),
		.wr0_o(wr0_o), .wr1_o(wr1_o), .fault_o(fault_o),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

	imd_issue_model pm (.clk_sys_i(clk_sys_i), .issue_ready_i(issue_ready_o),
		.fault_i(fault_o), .wr0_i(wr0_o), .wr1_i(wr1_o),
		.issue_valid_o(issue_valid_i), .insn_o(insn_i),
		.src1_val_o(src1_val_i), .src2_val_o(src2_val_i));

	// ========================================================================
	// Helpers
	// ========================================================================
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic final_report();
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [63:0] s,
			input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic rnd(output logic [63:0] r);
		repeat (4) begin
			seed = lfsr(seed);
			r = {r[47:0], seed};
		end
	endtask

	// Operand of one lane, masked and optionally sign-extended
	function automatic logic signed [127:0] ext(input logic [63:0] x,
			input int wd, input logic s);
		logic [127:0] m;
		m = (128'h1 << wd) - 1;
		ext = x & m;
		if (s && x[wd-1])
			ext = ext | ~m;
	endfunction

	// Reference results, lane by lane, with wide signed arithmetic
	function automatic void model(input logic [31:0] w, input logic [63:0] s1,
			input logic [63:0] s2, output logic [63:0] lo,
			output logic [63:0] hi, output logic two, output logic flt,
			output logic ok);
		int                  wd;
		logic signed [127:0] a;
		logic signed [127:0] b;
		logic signed [127:0] r;
		logic signed [127:0] h;
		logic [127:0]        m;
		logic [7:0]          op;
		logic                sg;
		logic                bs;
		op = w[31:24];
		wd = 8 << w[23:22];
		m = (128'h1 << wd) - 1;
		lo = '0;
		hi = '0;
		flt = 1'b0;
		two = (op == OPC[1]) ? w[18] : (op == OPC[3] || op == OPC[4]) & w[20];
		sg = (op == OPC[4]) || w[19];
		bs = (op == OPC[1] || op == OPC[3]) ? sg : (op != OPC[0]);
		for (int k = 0; k < (w[21] ? 64 / wd : 1); k++) begin
			a = ext(op == OPC[3] ? s2 >> (k * wd) : s1 >> (k * wd), wd, sg);
			b = ext(op == OPC[3] ? s1 >> (k * wd) : op == OPC[1] ?
				s2 >> (k * wd) : {{56{bs & w[19]}}, w[19:12]}, wd, bs);
			r = '0;
			h = '0;
			ok = 1'b1;
			case (op)
				OPC[0]: r = a - b;
				OPC[1], OPC[2]: begin
					r = a * b;
					h = r >>> wd;
				end
				OPC[3], OPC[4]: begin
					if (b == 0)
						flt = 1'b1;
					else begin
						r = a / b;
						h = a % b;
					end
				end
				default: ok = 1'b0;
			endcase
			lo = lo | 64'((r & m) << (k * wd));
			hi = hi | 64'((h & m) << (k * wd));
		end
	endfunction

	// One instruction; expected writes are queued with their due cycle
	task automatic issue(input logic [31:0] w);
		logic [63:0] a1;
		logic [63:0] a2;
		logic [63:0] lo;
		logic [63:0] hi;
		logic        f;
		logic        tk;
		logic        two;
		logic        flt;
		logic        ok;
		logic        bm;
		int          nw;
		bm = (w[31:24] == OPC[0]) && (w[23:22] == 2'h0);
		pm.offer(w, a1, a2, f, tk, nw);
		if (!tk) begin
			n_mismatch++;
			final_report();
		end
		model(w, a1, a2, lo, hi, two, flt, ok);
		check("fault", f, flt);
		check("stall", nw, bm && prev2);
		exp_st = exp_st | {~ok, ok & ~flt, flt};
		if (flt)
			exp_fi = w;
		if (ok && !flt)
			q.push_back('{cyc + (bm ? 1 : 2), two, w[5:0], lo, hi});
		prev2 = ok && !flt && !bm;
	endtask

	task automatic drain();
		pm.idle();
		prev2 = 1'b0;
		for (int t = 0; t < 8 && q.size() > 0; t++)
			@(negedge clk_sys_i);
		if (q.size() > 0) begin
			n_mismatch++;
			final_report();
		end
		@(posedge clk_sys_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		check("rdata", reg_rdata_o, e);
		check("irq", irq_o, |(exp_st & exp_mask));
		@(posedge clk_sys_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	// Every cycle: writes appear exactly when due, and nowhere else
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (!reset_i) begin
			hit = q.size() > 0 && q[0].due == cyc;
			check("wr0_we", wr0_o.we, hit);
			check("wr1_we", wr1_o.we, hit && q[0].two);
			if (hit) begin
				check("wr0_idx", wr0_o.idx, q[0].idx);
				check("wr0_data", wr0_o.data, q[0].lo);
				if (q[0].two) begin
					check("wr1_idx", wr1_o.idx, q[0].idx ^ 6'h01);
					check("wr1_data", wr1_o.data, q[0].hi);
				end
				void'(q.pop_front());
			end
		end
	end

	// ========================================================================
	// Main sequence
	// ========================================================================
	initial begin
		{reset_i, ce_i} = 2'h3;
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		{n_mismatch, num_checks, cyc} = '0;
		{exp_st, exp_mask, exp_fi, prev2} = '0;
		seed = 16'h0040;
		pm.rf[0] = '0;
		pm.rf[1] = '0;
		for (int i = 2; i < 64; i++) begin
			rnd(v);
			pm.rf[i] = v;
		end
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(imd_pkg::REG_STATUS, 32'h0);
		rd(imd_pkg::REG_MASK, 32'h0);
		// Every opcode, size, lane mode and flag pair, back to back
		for (int op = 0; op < 5; op++) begin
			for (int c = 0; c < 32; c++) begin
				rnd(v);
				w = {OPC[op], c[4:2], v[20:6], v[5:1] | 5'h01, v[0]};
				case (op)
					1: w[20:18] = {1'b0, c[1:0]};
					3: w[20:18] = {c[1:0], 1'b0};
					4: w[20] = c[0];
					default: w[20] = 1'b0;
				endcase
				issue(w);
			end
		end
		drain();
		rd(imd_pkg::REG_STATUS, {29'h0, exp_st});
		wr(imd_pkg::REG_STATUS, 32'h7);
		exp_st = '0;
		rd(imd_pkg::REG_STATUS, 32'h0);
		wr(imd_pkg::REG_MASK, 32'h1);
		exp_mask = 3'h1;
		// Zero divisor register, then zero constant divisor
		issue({OPC[3], 6'h36, 6'd9, 6'd0, 6'd20});
		issue({OPC[4], 4'h7, 8'h00, 6'd9, 6'd21});
		drain();
		rd(imd_pkg::REG_STATUS, {29'h0, exp_st});
		rd(imd_pkg::REG_FAULT, exp_fi);
		wr(imd_pkg::REG_FAULT, 32'h0000ffff);
		wr(8'h10, 32'h7);
		rd(imd_pkg::REG_FAULT, exp_fi);
		rd(8'h0c, 32'h0);
		wr(imd_pkg::REG_STATUS, 32'h1);
		exp_st = exp_st & 3'h6;
		rd(imd_pkg::REG_STATUS, {29'h0, exp_st});
		// Byte minus right behind a wide minus waits one cycle
		issue({OPC[0], 4'h4, 8'h85, 6'd3, 6'd10});
		issue({OPC[0], 4'h2, 8'hf1, 6'd10, 6'd11});
		// Unknown opcode raises its own event
		issue({8'hee, 24'h000000});
		drain();
		wr(imd_pkg::REG_MASK, 32'h4);
		exp_mask = 3'h4;
		rd(imd_pkg::REG_STATUS, {29'h0, exp_st});
		// Clock enable low: a mask write must be lost
		ce_i <= 1'b0;
		wr(imd_pkg::REG_MASK, 32'h0);
		ce_i <= 1'b1;
		rd(imd_pkg::REG_MASK, 32'h4);
		final_report();
	end
endmodule // tb_integer_sub_mul_div_datapath

`default_nettype wire
